// ==== core/anps_defines.vh ====
// Constants for the partner-status register pair: addresses, fields, resets.
// Assumes inclusion by bare name from the register bank and its page loader.
// Overview of operation
// - Partner ability bit 15 shows the partner can send multiple pages.
// - Partner ability bit 14 shows the partner acknowledged our code word.
// - Bit 13 shows partner remote fault; reserved bit 12 reads zero.
// - Bits 11 and 10 show partner asymmetric and symmetric pause ability.
// - Bits 9 down to 5 show the partner's five technology abilities.
// - Low five bits hold the partner selector code from the received page.
// - Expansion bit 5 latches high on base page; meaningful in alternate mode.
// - Expansion bit 4 latches high on parallel detection fault until read.
// - Expansion bit 3 partner next-page able, bit 0 partner autoneg able.
// - Expansion bit 2 always reads one: local device is next-page able.
// - Page-received bit 1 latches high and clears on expansion read.
// - In alternate mode, page-received also clears on no page or tx disable.
// - New page sets page-received, loads base to reg 5 or next to reg 8.
`ifndef ANPS_DEFINES_VH
`define ANPS_DEFINES_VH
`define ANPS_ADDR_ABILITY 5'h05
`define ANPS_ADDR_EXPANSION 5'h06
`define ANPS_ADDR_NEXT_PAGE 5'h08
`define ANPS_ABIL_RSVD_BIT 12
`define ANPS_ABIL_ACK_BIT 14
`define ANPS_ABIL_RF_BIT 13
`define ANPS_ABIL_ASYM_BIT 11
`define ANPS_ABIL_PAUSE_BIT 10
`define ANPS_ABIL_T4_BIT 9
`define ANPS_ABIL_TX_FD_BIT 8
`define ANPS_ABIL_TX_BIT 7
`define ANPS_ABIL_10_FD_BIT 6
`define ANPS_ABIL_10_BIT 5
`define ANPS_ABIL_SEL_HI 4
`define ANPS_ABIL_SEL_LO 0
`define ANPS_EXP_BASE_PAGE 5
`define ANPS_EXP_PD_FAULT 4
`define ANPS_EXP_LP_NP_ABLE 3
`define ANPS_EXP_NP_ABLE 2
`define ANPS_EXP_PAGE_RX 1
`define ANPS_EXP_LP_AN_ABLE 0
`define ANPS_CW_NP_BIT 15
`define ANPS_ABILITY_RESET 16'h0000
`define ANPS_NEXT_PAGE_RESET 16'h0000
`define ANPS_NP_ABLE_VALUE 1'b1
`endif

// ==== core/anps_page_store.v ====
// Holds the received code word for one page register and its reserved mask.
// Assumes load strobes come from logic on the same clock.
`timescale 1ns/10ps
`include "anps_defines.vh"
module anps_page_store #(
   parameter WIDTH = 16,
   parameter [15:0] RESET_VALUE = 16'h0000,
   parameter [15:0] KEEP_MASK = 16'hffff
) (
   input wire clock_in,
   input wire rst_n_in,
   input wire load_in,
   input wire [WIDTH-1:0] word_in,
   output wire [WIDTH-1:0] value_out
);
   reg [WIDTH-1:0] word_q;
   // Capture the page word; reserved bits forced to zero
   always @(posedge clock_in) begin
      if (!rst_n_in) begin
         word_q <= RESET_VALUE[WIDTH-1:0];
      end else if (load_in) begin
         word_q <= word_in & KEEP_MASK[WIDTH-1:0];
      end
   end
   assign value_out = word_q;
endmodule

// ==== core/anps_regs.v ====
// Partner base-page ability and auto-negotiation expansion registers.
// Assumes the negotiation engine and management port share clock_in.
`timescale 1ns/10ps
`include "anps_defines.vh"
module anps_regs (
   input wire clock_in,
   input wire rst_n_in,
   input wire page_rx_in,
   input wire page_is_next_in,
   input wire [15:0] code_word_in,
   input wire pd_fault_in,
   input wire base_page_in,
   input wire mr_page_rx_in,
   input wire transmit_disable_in,
   input wire lp_an_able_in,
   input wire alternate_next_page_mode_in,
   input wire rd_en_in,
   input wire wr_en_in,
   input wire [4:0] reg_addr_in,
   input wire [15:0] wr_data_in,
   output reg [15:0] rd_data_out,
   output wire [15:0] next_page_word_out
);
   localparam [15:0] ABIL_KEEP = ~(16'h0001 << `ANPS_ABIL_RSVD_BIT);
   wire [15:0] ability_w;
   wire [15:0] ability_rd_w;
   wire lp_next_page_w;
   wire lp_ack_w;
   wire lp_remote_fault_w;
   wire lp_asym_pause_w;
   wire lp_sym_pause_w;
   wire lp_t4_w;
   wire lp_tx_fd_w;
   wire lp_tx_w;
   wire lp_10_fd_w;
   wire lp_10_w;
   wire [4:0] lp_selector_w;
   wire load_base_w;
   wire load_next_w;
   wire exp_read_w;
   wire abil_read_w;
   wire alt_clear_w;
   wire page_rx_d;
   wire pd_fault_d;
   wire base_page_d;
   wire lp_np_able_d;
   wire exp_base_page_w;
   wire exp_pd_fault_w;
   wire exp_lp_np_able_w;
   wire exp_np_able_w;
   wire exp_page_rx_w;
   wire exp_lp_an_able_w;
   reg page_rx_q;
   reg pd_fault_q;
   reg base_page_q;
   reg lp_np_able_q;
   reg [15:0] exp_w;
   reg [15:0] rd_data_d;

   // Latching-high next value; a set beats a clear in the same cycle
   function latch_next;
      input cur;
      input set;
      input clr;
      begin
         if (set) begin
            latch_next = 1'b1;
         end else if (clr) begin
            latch_next = 1'b0;
         end else begin
            latch_next = cur;
         end
      end
   endfunction

   // Register select: a read strobe aimed at one address
   function reg_hit;
      input rd_en;
      input [4:0] addr;
      input [4:0] target;
      begin
         reg_hit = rd_en && (addr == target);
      end
   endfunction

   // Route a new page to register 5 or 8
   assign load_base_w = page_rx_in & ~page_is_next_in;
   assign load_next_w = page_rx_in & page_is_next_in;
   // Read selects for the two mapped addresses
   assign abil_read_w = reg_hit(rd_en_in, reg_addr_in, `ANPS_ADDR_ABILITY);
   assign exp_read_w = reg_hit(rd_en_in, reg_addr_in, `ANPS_ADDR_EXPANSION);
   // Extra page-received clear, alternate mode only
   assign alt_clear_w = alternate_next_page_mode_in &
                        (~mr_page_rx_in | transmit_disable_in);

   // Flag next values through the shared latching rule
   assign page_rx_d = latch_next(page_rx_q, page_rx_in, exp_read_w | alt_clear_w);
   assign pd_fault_d = latch_next(pd_fault_q, pd_fault_in, exp_read_w);
   assign base_page_d = latch_next(base_page_q, base_page_in, exp_read_w);
   // Partner next-page ability follows the NP bit of each base page
   assign lp_np_able_d = load_base_w ? code_word_in[`ANPS_CW_NP_BIT] : lp_np_able_q;

   // Base page word: NP, ACK, RF, pause bits, abilities, selector
   anps_page_store #(
      .WIDTH(16),
      .RESET_VALUE(`ANPS_ABILITY_RESET),
      .KEEP_MASK(ABIL_KEEP)
   ) u_base (
      .clock_in(clock_in),
      .rst_n_in(rst_n_in),
      .load_in(load_base_w),
      .word_in(code_word_in),
      .value_out(ability_w)
   );

   // Next page word for the register 8 holder
   anps_page_store #(
      .WIDTH(16),
      .RESET_VALUE(`ANPS_NEXT_PAGE_RESET),
      .KEEP_MASK(16'hffff)
   ) u_next (
      .clock_in(clock_in),
      .rst_n_in(rst_n_in),
      .load_in(load_next_w),
      .word_in(code_word_in),
      .value_out(next_page_word_out)
   );

   // Split the stored base page into its named fields
   assign lp_next_page_w = ability_w[`ANPS_CW_NP_BIT];
   assign lp_ack_w = ability_w[`ANPS_ABIL_ACK_BIT];
   assign lp_remote_fault_w = ability_w[`ANPS_ABIL_RF_BIT];
   assign lp_asym_pause_w = ability_w[`ANPS_ABIL_ASYM_BIT];
   assign lp_sym_pause_w = ability_w[`ANPS_ABIL_PAUSE_BIT];
   assign lp_t4_w = ability_w[`ANPS_ABIL_T4_BIT];
   assign lp_tx_fd_w = ability_w[`ANPS_ABIL_TX_FD_BIT];
   assign lp_tx_w = ability_w[`ANPS_ABIL_TX_BIT];
   assign lp_10_fd_w = ability_w[`ANPS_ABIL_10_FD_BIT];
   assign lp_10_w = ability_w[`ANPS_ABIL_10_BIT];
   assign lp_selector_w = ability_w[`ANPS_ABIL_SEL_HI:`ANPS_ABIL_SEL_LO];
   // Reassembled ability word; reserved bit tied low so no stray load shows
   assign ability_rd_w = {lp_next_page_w, lp_ack_w, lp_remote_fault_w, 1'b0,
                          lp_asym_pause_w, lp_sym_pause_w, lp_t4_w, lp_tx_fd_w,
                          lp_tx_w, lp_10_fd_w, lp_10_w, lp_selector_w};

   // Expansion fields; base page bit only means something in alternate mode
   assign exp_base_page_w = base_page_q & alternate_next_page_mode_in;
   assign exp_pd_fault_w = pd_fault_q;
   assign exp_lp_np_able_w = lp_np_able_q;
   assign exp_np_able_w = `ANPS_NP_ABLE_VALUE;
   assign exp_page_rx_w = page_rx_q;
   assign exp_lp_an_able_w = lp_an_able_in;

   // Page-received flag
   always @(posedge clock_in) begin
      if (!rst_n_in) begin
         page_rx_q <= 1'b0;
      end else begin
         page_rx_q <= page_rx_d;
      end
   end

   // Parallel detection fault flag
   always @(posedge clock_in) begin
      if (!rst_n_in) begin
         pd_fault_q <= 1'b0;
      end else begin
         pd_fault_q <= pd_fault_d;
      end
   end

   // Base page flag
   always @(posedge clock_in) begin
      if (!rst_n_in) begin
         base_page_q <= 1'b0;
      end else begin
         base_page_q <= base_page_d;
      end
   end

   // Partner next-page able bit
   always @(posedge clock_in) begin
      if (!rst_n_in) begin
         lp_np_able_q <= 1'b0;
      end else begin
         lp_np_able_q <= lp_np_able_d;
      end
   end

   // Expansion word assembly, upper bits zero
   always @* begin
      exp_w = 16'h0000;
      exp_w[`ANPS_EXP_BASE_PAGE] = exp_base_page_w;
      exp_w[`ANPS_EXP_PD_FAULT] = exp_pd_fault_w;
      exp_w[`ANPS_EXP_LP_NP_ABLE] = exp_lp_np_able_w;
      exp_w[`ANPS_EXP_NP_ABLE] = exp_np_able_w;
      exp_w[`ANPS_EXP_PAGE_RX] = exp_page_rx_w;
      exp_w[`ANPS_EXP_LP_AN_ABLE] = exp_lp_an_able_w;
   end

   // Read data next value; unmapped addresses return zero
   always @* begin
      rd_data_d = rd_data_out;
      if (abil_read_w) begin
         rd_data_d = ability_rd_w;
      end else if (exp_read_w) begin
         rd_data_d = exp_w;
      end else if (rd_en_in) begin
         rd_data_d = 16'h0000;
      end
   end

   // Read data register, held between reads
   always @(posedge clock_in) begin
      if (!rst_n_in) begin
         rd_data_out <= 16'h0000;
      end else begin
         rd_data_out <= rd_data_d;
      end
   end

   // Write strobe and data have no target: both registers are read-only
   // so a write leaves every field and flag as it was
endmodule

// ==== test/anps_regs_sva.sv ====
// Checker on the partner-status register ports.
// Assumes one clock with a synchronous active-low reset.
`timescale 1ns/10ps
module anps_sva (input wire clock_in, input wire rst_n_in, input wire rd_en_in,
   input wire [4:0] reg_addr_in, input wire [15:0] rd_data_out, input wire page_rx_in,
   input wire page_is_next_in, input wire [15:0] code_word_in,
   input wire alternate_next_page_mode_in, input wire [15:0] next_page_word_out);
   default clocking @(posedge clock_in); endclocking
   default disable iff (!rst_n_in);
   // Reads of the two registers
   wire r5 = rd_en_in && reg_addr_in == 5'h05;
   wire r6 = rd_en_in && reg_addr_in == 5'h06;
   // Read data and page loads
   chk_np_able: assert property (r6 |=> rd_data_out[2]) else $error("np");
   chk_exp_zero: assert property (r6 |=> !rd_data_out[15:6]) else $error("top");
   chk_rsvd_zero: assert property (r5 |=> !rd_data_out[12]) else $error("b12");
   chk_rd_hold: assert property (!rd_en_in |=> $stable(rd_data_out)) else $error("hold");
   chk_next_load: assert property (page_rx_in && page_is_next_in |=>
      next_page_word_out == $past(code_word_in)) else $error("next");
   chk_next_keep: assert property (!page_rx_in |=> $stable(next_page_word_out))
      else $error("keep");
   chk_base_load: assert property (page_rx_in && !page_is_next_in ##1 !page_rx_in ##1 r5
      |=> rd_data_out == ($past(code_word_in, 3) & 16'hefff)) else $error("base");
   chk_rx_flag: assert property (page_rx_in ##1 !rd_en_in ##1 r6
      && !alternate_next_page_mode_in |=> rd_data_out[1]) else $error("rx");
   cover property (page_rx_in && page_is_next_in);
   cover property (r6 && alternate_next_page_mode_in);
   cover property (r5);
endmodule
bind anps_regs anps_sva u_sva (
   .clock_in(clock_in),
   .rst_n_in(rst_n_in),
   .rd_en_in(rd_en_in),
   .reg_addr_in(reg_addr_in),
   .rd_data_out(rd_data_out),
   .page_rx_in(page_rx_in),
   .page_is_next_in(page_is_next_in),
   .code_word_in(code_word_in),
   .alternate_next_page_mode_in(alternate_next_page_mode_in),
   .next_page_word_out(next_page_word_out)
);

// ==== test/anps_partner.sv ====
// Remote link partner: sends one code word per call.
// Assumes the bank samples on the rising clock.
`timescale 1ns/10ps
module anps_partner (input wire clock_in, output reg page_rx_out = 0,
   output reg is_next_out = 0, output reg [15:0] word_out = 16'h0000);
   task send(input n, input [15:0] w);
      begin
         is_next_out = n;
         word_out = w;
         @(negedge clock_in) page_rx_out = 1;
         @(negedge clock_in) page_rx_out = 0;
         word_out = ~w; // Stale word is not held
      end
   endtask
endmodule

// ==== test/tb_anps_regs.sv ====
// Bench for the partner-status registers.
// Assumes the partner model supplies received pages.
`timescale 1ns/10ps
module tb_anps_regs;
   reg clock_in = 0, rst_n_in = 0, pd_fault_in = 0, base_page_in = 0, mr_page_rx_in = 1;
   reg transmit_disable_in = 0, lp_an_able_in = 1, alternate_next_page_mode_in = 0;
   reg rd_en_in = 0, wr_en_in = 0;
   reg [4:0] reg_addr_in = 5'h00;
   reg [15:0] wr_data_in = 16'hffff;
   wire page_rx_in, page_is_next_in;
   wire [15:0] code_word_in, rd_data_out, next_page_word_out;
   integer n_fail = 0, n_compared = 0;
   // Clock
   always #2 clock_in = ~clock_in;
   anps_partner lp (.clock_in(clock_in), .page_rx_out(page_rx_in),
      .is_next_out(page_is_next_in), .word_out(code_word_in));
   anps_regs DUT (
      .clock_in(clock_in),
      .rst_n_in(rst_n_in),
      .page_rx_in(page_rx_in),
      .page_is_next_in(page_is_next_in),
      .code_word_in(code_word_in),
      .pd_fault_in(pd_fault_in),
      .base_page_in(base_page_in),
      .mr_page_rx_in(mr_page_rx_in),
      .transmit_disable_in(transmit_disable_in),
      .lp_an_able_in(lp_an_able_in),
      .alternate_next_page_mode_in(alternate_next_page_mode_in),
      .rd_en_in(rd_en_in),
      .wr_en_in(wr_en_in),
      .reg_addr_in(reg_addr_in),
      .wr_data_in(wr_data_in),
      .rd_data_out(rd_data_out),
      .next_page_word_out(next_page_word_out)
   );
   // Read one register and compare
   task rd(input [4:0] a, input [15:0] e);
      begin
         reg_addr_in = a;
         @(negedge clock_in) rd_en_in = 1;
         @(negedge clock_in) rd_en_in = 0;
         @(negedge clock_in) n_compared = n_compared + 1;
         if (rd_data_out !== e) begin
            n_fail = n_fail + 1;
            $display("CHECK FAILED %0t got %h", $time, rd_data_out);
         end
      end
   endtask
   // Compare the held next-page word
   task cmp_next(input [15:0] e);
      begin
         n_compared = n_compared + 1;
         if (next_page_word_out !== e) begin
            n_fail = n_fail + 1;
            $display("CHECK FAILED %0t next %h", $time, next_page_word_out);
         end
      end
   endtask
   task s_base;
      begin
         lp.send(1'b0, 16'hffff);
         rd(5'h05, 16'hefff);
         rd(5'h06, 16'h000f);
         rd(5'h06, 16'h000d);
         lp.send(1'b0, 16'h0002);
         rd(5'h06, 16'h0007);
         pd_fault_in = 1;
         @(negedge clock_in) pd_fault_in = 0;
         rd(5'h06, 16'h0015);
         rd(5'h06, 16'h0005);
      end
   endtask
   task s_alt;
      begin
         alternate_next_page_mode_in = 1;
         base_page_in = 1;
         mr_page_rx_in = 0;
         lp.send(1'b0, 16'h0001);
         base_page_in = 0;
         rd(5'h05, 16'h0001);
         rd(5'h06, 16'h0025);
      end
   endtask
   task s_next;
      begin
         mr_page_rx_in = 1;
         transmit_disable_in = 1;
         lp.send(1'b1, 16'h1234);
         cmp_next(16'h1234);
         reg_addr_in = 5'h05;
         wr_en_in = 1;
         @(negedge clock_in) wr_en_in = 0;
         rd(5'h05, 16'h0001);
         rd(5'h09, 16'h0000);
         rd(5'h06, 16'h0005);
      end
   endtask
   task s_reset;
      begin
         rst_n_in = 0;
         repeat (2) @(negedge clock_in);
         rst_n_in = 1;
         rd(5'h05, 16'h0000);
         rd(5'h06, 16'h0005);
         cmp_next(16'h0000);
      end
   endtask
   task give_verdict;
      begin
         if (n_fail == 0 && n_compared > 0) $display("RESULT: PASS");
         else $display("RESULT: FAIL");
         $finish;
      end
   endtask
   // Watchdog
   initial begin
      #2000 n_fail = n_fail + 1;
      give_verdict;
   end
   // Main sequence
   initial begin
      repeat (6) @(negedge clock_in);
      rst_n_in = 1;
      rd(5'h06, 16'h0005);
      s_base;
      s_alt;
      s_next;
      s_reset;
      give_verdict;
   end
endmodule
